// ---- pcm_pkg.sv ----
package pcm_pkg;

    // ************************************************************
    // register offsets on the control bus
    // ************************************************************
    localparam logic [7:0] OFF_PORT_SEL    = 8'h1e;
    localparam logic [7:0] OFF_METER       = 8'h1f;
    localparam logic [7:0] OFF_CAP_ONE     = 8'h20;
    localparam logic [7:0] OFF_CAP_TWO     = 8'h21;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int BIT_FIRST_PORT  = 0;
    localparam int BIT_SECOND_PORT = 1;
    localparam int BIT_HOLD        = 7;
    localparam int BIT_CODE_LOW    = 6;
    localparam int BIT_TWO_LINK    = 3;
    localparam int BIT_SECONDARY   = 2;
    localparam int BIT_WIDE_AUDIO  = 1;
    localparam int BIT_FWD_PINS    = 0;
    localparam int BIT_ENH_CHECK   = 3;
    localparam logic [7:0] CAP_ONE_MASK  = 8'hcf;
    localparam logic [7:0] CAP_TWO_MASK  = 8'h0b;
    localparam logic [7:0] PORT_SEL_MASK = 8'h03;
    localparam logic [7:0] PORT_SEL_RST  = 8'h01;
    localparam logic [7:0] CAP_RST       = 8'h00;
    localparam logic [7:0] METER_RST     = 8'h00;
    localparam logic [7:0] TALLY_MAX     = 8'hff;

    // ************************************************************
    // timing: one window tick is one oscillator period
    // ************************************************************
    localparam int OSC_PERIOD_NS = 40;
    localparam int SYS_PERIOD_NS = 10;
    localparam int OSC_TICK_CYC  = (OSC_PERIOD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

    // ************************************************************
    // fast control channel codes
    // ************************************************************
    typedef enum logic [2:0] {
        PCM_CODE_NORMAL  = 3'h0,
        PCM_CODE_GPIO1   = 3'h1,
        PCM_CODE_GPIO2   = 3'h2,
        PCM_CODE_GPIO4   = 3'h3,
        PCM_CODE_RSV4    = 3'h4,
        PCM_CODE_RSV5    = 3'h5,
        PCM_CODE_FWD_SPI = 3'h6,
        PCM_CODE_REV_SPI = 3'h7
    } pcm_code_e;

    typedef struct packed {
        logic       twoLink;
        logic       secondary;
        logic       wideAudio;
        logic       fwdPins;
        logic [2:0] code;
        logic       enhCheck;
    } pcm_cap_s;

    typedef enum {
        PCM_IDLE,
        PCM_COUNT
    } pcm_meter_e;

endpackage

// ---- pcm_pixclk_meter_caps.sv ----
`timescale 1ns/1ps

// Contract
// [RL1] a meter write opens a window of value times oscillator periods
// [RL2] meter reads return pixel edges seen in the latest window
// [RL3] edge tally saturates at 0xff, never wraps
// [RL4] hold bit set blocks back-channel loading, keeps software values
// [RL5] code bit 0 sits in first capability bit 6, bits 2:1 in second
// [RL6] unheld capability fields reload from back channel after receive lock
// [RL7] software overwriting a field must also set the hold bit
// [RL8] first capability bit 3 shows peer two-link support
// [RL9] bit 2 shows primary (0) or secondary (1) channel
// [RL10] bit 1 shows peer wide video together with audio
// [RL11] bit 0 shows peer forward-channel pin support
// [RL12] second capability bit 3 enables enhanced check and start sequence
// [RL13] code decodes normal, fast pins 1/2/4, reserved, forward or reverse SPI
// [RL14] a single-link device supports only normal back channel code
// [RL15] capabilities kept per port; port select picks the accessed copy
// [RL16] writes go to selected port and shared; port 1 selected reads port 1; with both selected, writes here reach port 1 only
// [RL17] reserved capability bits read zero and ignore writes
// [RL18] meter write clears tally and restarts window; pixel clock synchronised
module pcm_pixclk_meter_caps #(
    parameter bit DUAL_LINK = 1'b1
) (
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    input  wire logic                pixClk,
    input  wire logic                regWrite,
    input  wire logic                regRead,
    input  wire logic [7:0]          regAddr,
    input  wire logic [7:0]          regWdata,
    output logic      [7:0]          regRdata,
    input  wire logic [1:0]          rxLock,
    input  wire logic [1:0]          peerValid,
    input  wire pcm_pkg::pcm_cap_s   peerCap0,
    input  wire pcm_pkg::pcm_cap_s   peerCap1,
    output pcm_pkg::pcm_cap_s        activeCap0,
    output pcm_pkg::pcm_cap_s        activeCap1,
    output logic [1:0]               enhCheckEn,
    output logic                     meterBusy
);

    // ************************************************************
    // synchronisers
    // ************************************************************
    logic       pixMeta;
    logic       pixSync;
    logic       pixLast;
    logic [1:0] lockMeta;
    logic [1:0] lockSync;
    logic [1:0] validMeta;
    logic [1:0] validSync;
    // capability words come from the back-channel domain; two stages, as on the
    // valid, keep the word in step with the synchronised valid that allows a load
    pcm_pkg::pcm_cap_s capMeta0;
    pcm_pkg::pcm_cap_s capMeta1;
    pcm_pkg::pcm_cap_s capSync0;
    pcm_pkg::pcm_cap_s capSync1;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            capMeta0  <= '0;
            capMeta1  <= '0;
            capSync0  <= '0;
            capSync1  <= '0;
        end else begin
            capMeta0  <= peerCap0;
            capMeta1  <= peerCap1;
            capSync0  <= capMeta0;
            capSync1  <= capMeta1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pixMeta   <= 1'b0;
            pixSync   <= 1'b0;
            pixLast   <= 1'b0;
            lockMeta  <= 2'b00;
            lockSync  <= 2'b00;
            validMeta <= 2'b00;
            validSync <= 2'b00;
        end else begin
            pixMeta   <= pixClk;
            pixSync   <= pixMeta;
            pixLast   <= pixSync;
            lockMeta  <= rxLock;
            lockSync  <= lockMeta;
            validMeta <= peerValid;
            validSync <= validMeta;
        end
    end

    // rising edges only; pixel clock above half of clk_sys is undercounted
    wire pixEdge = pixSync & ~pixLast;

    // ************************************************************
    // port select (shared)
    // ************************************************************
    logic [7:0] portSel_reg;
    wire        selSecond = portSel_reg[pcm_pkg::BIT_SECOND_PORT];
    wire        selFirst  = portSel_reg[pcm_pkg::BIT_FIRST_PORT];
    wire        hitSel    = regWrite && (regAddr == pcm_pkg::OFF_PORT_SEL);
    wire        hitMeter  = regWrite && (regAddr == pcm_pkg::OFF_METER);
    wire        hitOne    = regWrite && (regAddr == pcm_pkg::OFF_CAP_ONE);
    wire        hitTwo    = regWrite && (regAddr == pcm_pkg::OFF_CAP_TWO);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            portSel_reg <= pcm_pkg::PORT_SEL_RST;
        end else if (hitSel) begin
            portSel_reg <= regWdata & pcm_pkg::PORT_SEL_MASK;
        end
    end

    // ************************************************************
    // frequency meter
    // ************************************************************
    pcm_pkg::pcm_meter_e meterState;
    logic [7:0] window_reg;
    logic [7:0] tally_reg;
    logic [3:0] tickCnt;
    wire        oscTick = (tickCnt == 4'(pcm_pkg::OSC_TICK_CYC - 1));

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meterState <= pcm_pkg::PCM_IDLE;
            window_reg <= pcm_pkg::METER_RST;
            tally_reg  <= pcm_pkg::METER_RST;
            tickCnt    <= 4'h0;
        end else if (hitMeter) begin
            // [RL18] clear and restart
            tally_reg  <= pcm_pkg::METER_RST;
            window_reg <= regWdata;
            tickCnt    <= 4'h0;
            meterState <= (regWdata == 8'h00) ? pcm_pkg::PCM_IDLE : pcm_pkg::PCM_COUNT;
        end else begin
            case (meterState)
                pcm_pkg::PCM_IDLE: begin
                    tickCnt <= 4'h0;
                end
                pcm_pkg::PCM_COUNT: begin
                    // [RL3] saturating tally
                    if (pixEdge && tally_reg != pcm_pkg::TALLY_MAX) begin
                        tally_reg <= tally_reg + 8'h01;
                    end
                    // [RL1] window of N oscillator periods
                    if (oscTick) begin
                        tickCnt <= 4'h0;
                        window_reg <= window_reg - 8'h01;
                        if (window_reg == 8'h01) begin
                            meterState <= pcm_pkg::PCM_IDLE;
                        end
                    end else begin
                        tickCnt <= tickCnt + 4'h1;
                    end
                end
                default: meterState <= pcm_pkg::PCM_IDLE;
            endcase
        end
    end

    assign meterBusy = (meterState == pcm_pkg::PCM_COUNT);

    // ************************************************************
    // per-port capability store
    // ************************************************************
    logic [7:0] capOne_reg [2];
    logic [7:0] capTwo_reg [2];
    pcm_pkg::pcm_cap_s peerIn [2];
    assign peerIn[0] = capSync0;
    assign peerIn[1] = capSync1;

    for (genvar p = 0; p < 2; p++) begin : g_port
        // [RL16] write targets the selected port copy; with both ports selected it reaches port 1 only, not both
        wire wrPort = (p == 1) ? selSecond : (selFirst && !selSecond);
        // [RL14] single link supports only normal code
        wire [2:0] peerCode = DUAL_LINK ? peerIn[p].code : 3'(pcm_pkg::PCM_CODE_NORMAL);
        wire load = lockSync[p] && validSync[p] && !capOne_reg[p][pcm_pkg::BIT_HOLD];

        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                capOne_reg[p] <= pcm_pkg::CAP_RST;
                capTwo_reg[p] <= pcm_pkg::CAP_RST;
            end else begin
                // [RL17] reserved bits masked
                if (hitOne && wrPort) begin
                    capOne_reg[p] <= regWdata & pcm_pkg::CAP_ONE_MASK;
                end else if (load) begin
                    // [RL6] auto-load after lock; [RL4] blocked by hold
                    capOne_reg[p] <= {1'b0, peerCode[0], 2'b00, peerIn[p].twoLink,
                                      peerIn[p].secondary, peerIn[p].wideAudio, peerIn[p].fwdPins};
                end
                if (hitTwo && wrPort) begin
                    capTwo_reg[p] <= regWdata & pcm_pkg::CAP_TWO_MASK;
                end else if (load) begin
                    // [RL5] upper code bits in second register
                    capTwo_reg[p] <= {4'h0, peerIn[p].enhCheck, 1'b0, peerCode[2:1]};
                end
            end
        end
    end

    // [RL8] [RL9] [RL10] [RL11] field decode to outputs
    function automatic pcm_pkg::pcm_cap_s pcmUnpack(input logic [7:0] one, input logic [7:0] two);
        pcm_pkg::pcm_cap_s c;
        c.twoLink   = one[pcm_pkg::BIT_TWO_LINK];
        c.secondary = one[pcm_pkg::BIT_SECONDARY];
        c.wideAudio = one[pcm_pkg::BIT_WIDE_AUDIO];
        c.fwdPins   = one[pcm_pkg::BIT_FWD_PINS];
        // [RL13] three-bit control channel code
        c.code      = {two[1:0], one[pcm_pkg::BIT_CODE_LOW]};
        // [RL12] enhanced check enable
        c.enhCheck  = two[pcm_pkg::BIT_ENH_CHECK];
        return c;
    endfunction

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            activeCap0 <= '0;
            activeCap1 <= '0;
            enhCheckEn <= 2'b00;
        end else begin
            activeCap0 <= pcmUnpack(capOne_reg[0], capTwo_reg[0]);
            activeCap1 <= pcmUnpack(capOne_reg[1], capTwo_reg[1]);
            enhCheckEn <= {capTwo_reg[1][pcm_pkg::BIT_ENH_CHECK], capTwo_reg[0][pcm_pkg::BIT_ENH_CHECK]};
        end
    end

    // ************************************************************
    // read data
    // ************************************************************
    // [RL15] port 1 copy when port 1 selected
    wire rdPort = selSecond;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            if (regAddr == pcm_pkg::OFF_PORT_SEL) begin
                regRdata <= portSel_reg;
            end else if (regAddr == pcm_pkg::OFF_METER) begin
                // [RL2] latest window tally
                regRdata <= tally_reg;
            end else if (regAddr == pcm_pkg::OFF_CAP_ONE) begin
                regRdata <= capOne_reg[rdPort];
            end else if (regAddr == pcm_pkg::OFF_CAP_TWO) begin
                regRdata <= capTwo_reg[rdPort];
            end else begin
                regRdata <= 8'h00;
            end
        end
    end

endmodule

// ---- pcm_pixclk_meter_caps_chk.sv ----
`timescale 1ns/1ps
module pcm_pixclk_meter_caps_chk (
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic       meterBusy
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire mWr = regWrite && regAddr == pcm_pkg::OFF_METER;
    a_meter_opens: assert property (mWr && regWdata != 8'h00 |=> meterBusy)
        else $error("meter write left busy low");
    a_zero_idle: assert property (mWr && regWdata == 8'h00 && !meterBusy |=> !meterBusy)
        else $error("zero meter write opened a window");
    a_window_one: assert property (mWr && regWdata == 8'h01 |=> meterBusy [*4] ##1 !meterBusy)
        else $error("one tick window not four cycles");
    a_busy_cause: assert property ($rose(meterBusy) |-> $past(regWrite) && $past(regAddr) == 8'h1f)
        else $error("window opened without meter write");
    a_rdata_stands: assert property (!regRead |=> $stable(regRdata))
        else $error("read data moved without read");
    a_unmapped_zero: assert property (regRead && (regAddr < 8'h1e || regAddr > 8'h21) |=> regRdata == 8'h00)
        else $error("unmapped read not zero");
    a_select_resv: assert property (regRead && regAddr == 8'h1e |=> regRdata[7:2] == 6'h00)
        else $error("port select reserved bits set");
    a_one_resv: assert property (regRead && regAddr == 8'h20 |=> regRdata[5:4] == 2'b00)
        else $error("first capability reserved bits set");
    a_two_resv: assert property (regRead && regAddr == 8'h21 |=> (regRdata & 8'hf4) == 8'h00)
        else $error("second capability reserved bits set");
endmodule

// ---- pcm_peer_model.sv ----
`timescale 1ns/1ps
module pcm_peer_model (
    input  wire logic              clk_sys,
    input  wire logic [1:0]        linkUp,
    input  wire logic              slow,
    input  wire logic              pixRun,
    input  wire logic [7:0]        pixHalf,
    input  wire pcm_pkg::pcm_cap_s capIn0,
    input  wire pcm_pkg::pcm_cap_s capIn1,
    output logic                   pixClk = 1'b0,
    output logic [1:0]             rxLock = 2'b00,
    output logic [1:0]             peerValid = 2'b00,
    output pcm_pkg::pcm_cap_s      peerCap0,
    output pcm_pkg::pcm_cap_s      peerCap1
);
    logic [1:0] validLate = 2'b00;
    // pixel clock stands low while not running
    always begin
        #(pixHalf);
        pixClk = pixRun ? ~pixClk : 1'b0;
    end
    always @(posedge clk_sys) begin
        rxLock <= linkUp;
        validLate <= rxLock;
        peerValid <= slow ? validLate : rxLock;
    end
    // stale data shows inverted so a premature load is visible
    assign peerCap0 = peerValid[0] ? capIn0 : ~capIn0;
    assign peerCap1 = peerValid[1] ? capIn1 : ~capIn1;
endmodule

// ---- pcm_pixclk_meter_caps_tb.sv ----
`timescale 1ns/1ps
module pcm_pixclk_meter_caps_tb;
    logic              clk_sys = 1'b0;
    logic              rst_n = 1'b0;
    logic              regWrite = 1'b0;
    logic              regRead = 1'b0;
    logic [7:0]        regAddr = 8'h00;
    logic [7:0]        regWdata = 8'h00;
    logic [7:0]        regRdata;
    logic              meterBusy;
    logic              pixClk;
    logic              slow = 1'b0;
    logic              pixRun = 1'b0;
    logic [7:0]        pixHalf = 8'h28;
    logic [1:0]        linkUp = 2'b00;
    logic [1:0]        rxLock;
    logic [1:0]        peerValid;
    logic [1:0]        enhCheckEn;
    logic [15:0]       exp0;
    logic [15:0]       exp1;
    pcm_pkg::pcm_cap_s peerCap0, peerCap1, activeCap0, activeCap1;
    pcm_pkg::pcm_cap_s capIn0 = '0;
    pcm_pkg::pcm_cap_s capIn1 = '0;
    pcm_pkg::pcm_cap_s singleCap0;
    int                nErrors = 0;
    int                numChecks = 0;
    always #5 clk_sys = ~clk_sys;
    pcm_peer_model u_peer (.clk_sys(clk_sys), .linkUp(linkUp), .slow(slow), .pixRun(pixRun),
        .pixHalf(pixHalf), .capIn0(capIn0), .capIn1(capIn1), .pixClk(pixClk), .rxLock(rxLock),
        .peerValid(peerValid), .peerCap0(peerCap0), .peerCap1(peerCap1));
    pcm_pixclk_meter_caps #(.DUAL_LINK(1'b1)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .pixClk(pixClk),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .rxLock(rxLock), .peerValid(peerValid), .peerCap0(peerCap0), .peerCap1(peerCap1),
        .activeCap0(activeCap0), .activeCap1(activeCap1), .enhCheckEn(enhCheckEn), .meterBusy(meterBusy));
    // single-link build, watched only for its forced control code
    pcm_pixclk_meter_caps #(.DUAL_LINK(1'b0)) u_dut_single (.clk_sys(clk_sys), .rst_n(rst_n), .pixClk(pixClk),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(),
        .rxLock(rxLock), .peerValid(peerValid), .peerCap0(peerCap0), .peerCap1(peerCap1),
        .activeCap0(singleCap0), .activeCap1(), .enhCheckEn(), .meterBusy());
    // ************************************************************
    // bus tasks
    // ************************************************************
    task automatic print_verdict();
        $display("checks %0d errors %0d", numChecks, nErrors);
        if (nErrors == 0 && numChecks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        numChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        {regWrite, regAddr, regWdata} = {1'b1, a, d};
        @(negedge clk_sys);
        regWrite = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge clk_sys);
        {regRead, regAddr} = {1'b1, a};
        @(negedge clk_sys);
        regRead = 1'b0;
    endtask
    task automatic rdChk(input string what, input logic [7:0] a, input logic [7:0] exp);
        rd(a);
        chk(what, exp, regRdata);
    endtask
    // hold bit reads zero after a load
    function automatic logic [15:0] capRegs(input pcm_pkg::pcm_cap_s c);
        return {4'h0, c.enhCheck, 1'b0, c.code[2:1], 1'b0, c.code[0], 2'b00, c.twoLink, c.secondary,
            c.wideAudio, c.fwdPins};
    endfunction
    // edge count checked within one, since the pixel clock phase is free
    task automatic meter(input logic [7:0] n, input logic [7:0] half);
        int k;
        int e;
        {pixHalf, pixRun} = {half, 1'b1};
        e = n * pcm_pkg::OSC_TICK_CYC * pcm_pkg::SYS_PERIOD_NS / (2 * half);
        wr(pcm_pkg::OFF_METER, n);
        for (k = 0; k < 2000 && meterBusy !== 1'b0; k++) @(negedge clk_sys);
        if (k == 2000) begin
            nErrors++;
            $display("wrong value meter idle expected 0 seen 1");
        end
        chk("meter busy", 8'h00, {7'h00, meterBusy});
        rd(pcm_pkg::OFF_METER);
        numChecks++;
        if ((regRdata + 1 >= e && regRdata <= e + 1) !== 1'b1 && (e < 255 || regRdata !== 8'hff)) begin
            nErrors++;
            $display("wrong value tally expected %0d seen %0d", e, regRdata);
        end
    endtask
    initial begin
        repeat (5) @(negedge clk_sys);
        rst_n = 1'b1;
        rdChk("select", pcm_pkg::OFF_PORT_SEL, pcm_pkg::PORT_SEL_RST);
        rdChk("cap one", pcm_pkg::OFF_CAP_ONE, pcm_pkg::CAP_RST);
        rdChk("cap two", pcm_pkg::OFF_CAP_TWO, pcm_pkg::CAP_RST);
        rdChk("meter", pcm_pkg::OFF_METER, pcm_pkg::METER_RST);
        rdChk("unmapped", 8'h22, 8'h00);
        wr(pcm_pkg::OFF_METER, 8'h00);
        meter(8'h01, 8'h28);
        meter(8'hff, 8'h0f);
        meter(8'h0a, 8'h28);
        for (int i = 0; i < 8; i++) begin
            // drop the link each pass so every load follows a fresh lock
            linkUp = 2'b00;
            repeat (8) @(negedge clk_sys);
            capIn0 = {4'ha, i[2:0], 1'b1};
            capIn1 = {4'h5, ~i[2:0], 1'b0};
            slow = i[0];
            {exp0, exp1} = {capRegs(capIn0), capRegs(capIn1)};
            linkUp = 2'b11;
            repeat (12) @(negedge clk_sys);
            wr(pcm_pkg::OFF_PORT_SEL, 8'h01);
            rdChk("port0 one", pcm_pkg::OFF_CAP_ONE, exp0[7:0]);
            rdChk("port0 two", pcm_pkg::OFF_CAP_TWO, exp0[15:8]);
            wr(pcm_pkg::OFF_PORT_SEL, 8'h03);
            rdChk("port1 one", pcm_pkg::OFF_CAP_ONE, exp1[7:0]);
            rdChk("port1 two", pcm_pkg::OFF_CAP_TWO, exp1[15:8]);
            chk("active0", capIn0, activeCap0);
            chk("check en", {6'h00, capIn1.enhCheck, capIn0.enhCheck}, {6'h00, enhCheckEn});
            chk("active1", capIn1, activeCap1);
            chk("single code", 8'h00, {5'h00, singleCap0.code});
        end
        wr(pcm_pkg::OFF_PORT_SEL, 8'h01);
        wr(pcm_pkg::OFF_CAP_ONE, 8'hff);
        wr(pcm_pkg::OFF_CAP_TWO, 8'hff);
        capIn0 = {4'h9, 3'h6, 1'b1};
        repeat (12) @(negedge clk_sys);
        rdChk("held one", pcm_pkg::OFF_CAP_ONE, pcm_pkg::CAP_ONE_MASK);
        rdChk("held two", pcm_pkg::OFF_CAP_TWO, pcm_pkg::CAP_TWO_MASK);
        wr(pcm_pkg::OFF_PORT_SEL, 8'h02);
        rdChk("port1 kept", pcm_pkg::OFF_CAP_ONE, exp1[7:0]);
        wr(pcm_pkg::OFF_CAP_ONE, 8'h80);
        rdChk("port1 written", pcm_pkg::OFF_CAP_ONE, 8'h80);
        wr(pcm_pkg::OFF_PORT_SEL, 8'h01);
        rdChk("port0 untouched", pcm_pkg::OFF_CAP_ONE, pcm_pkg::CAP_ONE_MASK);
        wr(pcm_pkg::OFF_CAP_ONE, 8'h00);
        exp0 = capRegs(capIn0);
        repeat (12) @(negedge clk_sys);
        rdChk("released", pcm_pkg::OFF_CAP_ONE, exp0[7:0]);
        rdChk("released two", pcm_pkg::OFF_CAP_TWO, exp0[15:8]);
        print_verdict();
    end
endmodule
bind pcm_pixclk_meter_caps pcm_pixclk_meter_caps_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .meterBusy(meterBusy));
